// ### common/lbc_pkg.sv
// Purpose: Shared constants and types of the long bandwidth counter.
// Assumes: Offsets are byte offsets inside one security-space frame.
// Notes:   Field widths that depend on the monitor count live in the top.
package lbc_pkg;

    // Frame offsets.
    localparam logic [11:0] OFS_SELECTOR = 12'h010;
    localparam logic [11:0] OFS_COUNT    = 12'h880;
    localparam logic [11:0] OFS_SNAPSHOT = 12'h890;

    // Field positions.
    localparam int SEL_MON_LSB = 0;
    localparam int SEL_RIS_LSB = 24;
    localparam int FLAG_BIT    = 63;

    // Byte count widths for the two settings of the width select.
    localparam int NARROW_W = 44;
    localparam int WIDE_W   = 63;

    // Reset values.
    localparam logic [63:0] RST_COUNT    = 64'h0;
    localparam logic [31:0] RST_SELECTOR = 32'h0;

    // Clock edges from a taken request to its acknowledge.
    localparam int RD_LATENCY = 2;

    typedef enum logic [1:0] {
        SP_SECURE = 2'b00,
        SP_NONSEC = 2'b01,
        SP_ROOT   = 2'b10,
        SP_REALM  = 2'b11
    } lbc_space_t;

    typedef enum logic [1:0] {
        K_NONE = 2'b00,
        K_SEL  = 2'b01,
        K_CNT  = 2'b10,
        K_SNAP = 2'b11
    } lbc_kind_t;

endpackage

// ### common/lbc_mem_if.sv
// Purpose: Port bundle between the counter bank and its snapshot store.
// Assumes: One write and one read per cycle.
// Notes:   Read data arrive one cycle after the address.
`timescale 1ns/100ps
interface lbc_mem_if #(
    parameter int AW = 5,
    parameter int DW = 64
);
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;

    modport owner (output we, output waddr, output wdata, output raddr,
                   input rdata);
    modport store (input we, input waddr, input wdata, input raddr,
                   output rdata);
endinterface

// ### verilog/lbc_snap_mem.sv
// Purpose: Snapshot store, one 64-bit word per monitor entry.
// Assumes: Write and read address may be equal; read sees the old word.
// Notes:   Entries never written read as zero.
`timescale 1ns/100ps
module lbc_snap_mem #(
    parameter int AW = 5
)(
    // Clock and control
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic ce_i,
    // Store port
    lbc_mem_if.store m
);
    localparam int NE = 1 << AW;

    logic [63:0] mem_q [NE];
    logic [NE-1:0] vld_q;
    logic [63:0] rdata_q;

    // The valid bits avoid resetting the array itself.
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            vld_q <= '0;
        end else if (ce_i && m.we) begin
            vld_q[m.waddr] <= 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (ce_i && m.we) begin
            mem_q[m.waddr] <= m.wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_q <= 64'h0;
        end else if (ce_i) begin
            rdata_q <= vld_q[m.raddr] ? mem_q[m.raddr] : 64'h0;
        end
    end

    assign m.rdata = rdata_q;
endmodule // lbc_snap_mem

// ### verilog/lbc_long_counter.sv
// Purpose: Long bandwidth counters and their snapshots, four spaces.
// Assumes: Traffic and capture inputs come from logic on clock_i.
// Notes:   Filtering of traffic happens upstream of trf_valid_i.
//
// Overview of operation
// - Bit 63 of the long count is the not-ready flag.
// - Narrow width: 44-bit count, bits 62 to 44 read zero.
// - Wide width: 63-bit count fills bits 62 to 0.
// - Count bytes of matching traffic since the monitor was last reset.
// - Each space's counter is reached only through its own frame.
// - The four spaces keep separate counters for their own partitions.
// - With instance select, the resource and monitor fields pick.
// - Without instance select, only the monitor field picks.
// - The count sits at 0x0880 in every frame, readable and writable.
// - Root and realm frames work only with the realm feature.
// - The snapshot is 64 bits, copying flag and count.
// - Snapshot exists only with monitoring, MBWU, long count and capture, else reads zero.
// - Bit 63 of the snapshot is the captured not-ready flag.
// - Narrow width: snapshot holds 44 bits, bits 62 to 44 zero.
// - Wide width: snapshot holds 63 bits below the flag.
// - Each space's snapshot follows that space's selector.
// - With instance select, snapshot follows resource and monitor.
// - The live long counter is 64 bits wide.
`timescale 1ns/100ps
module lbc_long_counter
    import lbc_pkg::*;
#(
    parameter int NUM_MON        = 4,
    parameter int NUM_RIS        = 2,
    parameter int BYTES_W        = 16,
    parameter bit LONG_WIDTH_SEL = 1'b0,
    parameter bit INSTANCE_SELECT_SUPPORTED        = 1'b1,
    parameter bit HAS_RME        = 1'b1,
    parameter bit MONITORING_SUPPORTED      = 1'b1,
    parameter bit HAS_MBWU       = 1'b1,
    parameter bit HAS_LONG       = 1'b1,
    parameter bit HAS_CAPTURE    = 1'b1
)(
    // Clock, reset, enable
    input  wire logic               clock_i,
    input  wire logic               srst_i,
    input  wire logic               ce_i,
    // Register access
    input  wire logic               acc_req_i,
    input  wire logic               acc_wr_i,
    input  wire logic [1:0]         acc_space_i,
    input  wire logic [11:0]        acc_addr_i,
    input  wire logic [63:0]        acc_wdata_i,
    output logic                    acc_ack_o,
    output logic [63:0]             acc_rdata_o,
    // Filtered traffic
    input  wire logic               trf_valid_i,
    input  wire logic [1:0]         trf_space_i,
    input  wire logic [7:0]         trf_ris_i,
    input  wire logic [15:0]        trf_mon_i,
    input  wire logic [BYTES_W-1:0] trf_bytes_i,
    // Capture event
    input  wire logic               cap_i,
    input  wire logic [1:0]         cap_space_i
);
    localparam int MW = $clog2(NUM_MON);
    localparam int RW = $clog2(NUM_RIS);
    localparam int IW = 2 + RW + MW;
    localparam int NE = 1 << IW;
    localparam int VW = LONG_WIDTH_SEL ? WIDE_W : NARROW_W;
    localparam logic [62:0] VMASK = 63'((64'h1 << VW) - 64'h1);
    localparam bit LONG_OK = MONITORING_SUPPORTED && HAS_MBWU && HAS_LONG;
    localparam bit CAP_OK  = LONG_OK && HAS_CAPTURE;
    localparam logic [31:0] SEL_MASK =
        32'(((64'h1 << RW) - 64'h1) << SEL_RIS_LSB) |
        32'(((64'h1 << MW) - 64'h1) << SEL_MON_LSB);

    if (NUM_MON < 2 || NUM_MON > 65536 || (1 << MW) != NUM_MON) begin : g_bm
        $error("NUM_MON must be a power of two from 2 to 65536");
    end
    if (NUM_RIS < 2 || NUM_RIS > 16 || (1 << RW) != NUM_RIS) begin : g_br
        $error("NUM_RIS must be a power of two from 2 to 16");
    end
    if (BYTES_W < 1 || BYTES_W > 32) begin : g_bb
        $error("BYTES_W must lie between 1 and 32");
    end

    // Entry index is space, resource instance, monitor.
    function automatic logic [IW-1:0] idx_of(input logic [1:0]  sp,
                                             input logic [31:0] sel);
        logic [RW-1:0] resource_instance_field;
        resource_instance_field = INSTANCE_SELECT_SUPPORTED ? sel[SEL_RIS_LSB +: RW] : '0;
        return {sp, resource_instance_field, sel[SEL_MON_LSB +: MW]};
    endfunction

    logic [31:0] sel_q [4];
    logic [63:0] cnt_q [NE];

    // Access decode.
    wire logic          acc_sp_ok = HAS_RME || !acc_space_i[1];
    wire logic          acc_go    = acc_req_i && acc_sp_ok;
    wire logic          hit_sel   = acc_go && acc_addr_i == OFS_SELECTOR;
    wire logic          hit_cnt   = acc_go && LONG_OK &&
                                    acc_addr_i == OFS_COUNT;
    wire logic          hit_snap  = acc_go && CAP_OK &&
                                    acc_addr_i == OFS_SNAPSHOT;
    wire logic          wr_sel    = hit_sel && acc_wr_i;
    wire logic          wr_cnt    = hit_cnt && acc_wr_i;
    wire logic          wr_snap   = hit_snap && acc_wr_i;
    wire logic [IW-1:0] acc_idx   = idx_of(acc_space_i,
                                           sel_q[acc_space_i]);
    wire logic [63:0]   wval      = {acc_wdata_i[FLAG_BIT],
                                     acc_wdata_i[62:0] & VMASK};
    wire lbc_kind_t     acc_kind  = hit_sel  ? K_SEL  :
                                    hit_cnt  ? K_CNT  :
                                    hit_snap ? K_SNAP : K_NONE;

    // Traffic decode.
    wire logic [RW-1:0] trf_ris   = INSTANCE_SELECT_SUPPORTED ? trf_ris_i[RW-1:0] : '0;
    wire logic [IW-1:0] trf_idx   = {trf_space_i, trf_ris,
                                     trf_mon_i[MW-1:0]};
    wire logic          trf_ok    = trf_valid_i && LONG_OK &&
                                    (HAS_RME || !trf_space_i[1]);
    wire logic [62:0]   trf_add   = 63'(trf_bytes_i);

    // Capture decode.
    wire logic [IW-1:0] cap_idx   = idx_of(cap_space_i,
                                           sel_q[cap_space_i]);
    wire logic          cap_fire  = cap_i && CAP_OK &&
                                    (HAS_RME || !cap_space_i[1]);

    // Selector per space.
    for (genvar s = 0; s < 4; s++) begin : g_sel
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                sel_q[s] <= RST_SELECTOR;
            end else if (ce_i && wr_sel && acc_space_i == 2'(s)) begin
                sel_q[s] <= acc_wdata_i[31:0] & SEL_MASK;
            end
        end
    end

    // Live counters; a software write beats traffic in the same cycle.
    for (genvar e = 0; e < NE; e++) begin : g_cnt
        wire logic         e_wr  = wr_cnt && acc_idx == IW'(e);
        wire logic         e_hit = trf_ok && trf_idx == IW'(e);
        wire logic [62:0]  e_sum = (cnt_q[e][62:0] + trf_add) & VMASK;
        always_ff @(posedge clock_i) begin
            if (srst_i) begin
                cnt_q[e] <= RST_COUNT;
            end else if (ce_i && e_wr) begin
                cnt_q[e] <= wval;
            end else if (ce_i && e_hit) begin
                cnt_q[e] <= {cnt_q[e][FLAG_BIT], e_sum};
            end
        end
    end

    // Snapshot store; a capture wins over a software write.
    lbc_mem_if #(.AW(IW), .DW(64)) mem ();

    assign mem.we    = cap_fire || wr_snap;
    assign mem.waddr = cap_fire ? cap_idx : acc_idx;
    assign mem.wdata = cap_fire ? cnt_q[cap_idx] : wval;
    assign mem.raddr = acc_idx;

    lbc_snap_mem #(.AW(IW)) u_snap (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .ce_i    (ce_i),
        .m       (mem)
    );

    // Read pipeline: stage one waits for the store, stage two answers.
    logic          p_vld_q;
    logic          p_rd_q;
    lbc_kind_t     p_kind_q;
    logic [1:0]    p_space_q;
    logic [IW-1:0] p_idx_q;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            p_vld_q   <= 1'b0;
            p_rd_q    <= 1'b0;
            p_kind_q  <= K_NONE;
            p_space_q <= 2'h0;
            p_idx_q   <= '0;
        end else if (ce_i) begin
            p_vld_q   <= acc_req_i;
            p_rd_q    <= acc_req_i && !acc_wr_i;
            p_kind_q  <= acc_kind;
            p_space_q <= acc_space_i;
            p_idx_q   <= acc_idx;
        end
    end

    logic [63:0] rd_val;
    always_comb begin
        case (p_kind_q)
            K_SEL:   rd_val = {32'h0, sel_q[p_space_q]};
            K_CNT:   rd_val = cnt_q[p_idx_q];
            K_SNAP:  rd_val = mem.rdata;
            default: rd_val = 64'h0;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            acc_ack_o   <= 1'b0;
            acc_rdata_o <= 64'h0;
        end else if (ce_i) begin
            acc_ack_o   <= p_vld_q;
            acc_rdata_o <= p_rd_q ? rd_val : 64'h0;
        end
    end

    // Helper state for the increment check.
    logic          h_hit_q;
    logic [IW-1:0] h_idx_q;
    logic [62:0]   h_exp_q;
    wire logic     h_clash = wr_cnt && acc_idx == trf_idx;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            h_hit_q <= 1'b0;
            h_idx_q <= '0;
            h_exp_q <= 63'h0;
        end else if (ce_i) begin
            h_hit_q <= trf_ok && !h_clash;
            h_idx_q <= trf_idx;
            h_exp_q <= (cnt_q[trf_idx][62:0] + trf_add) & VMASK;
        end
    end

    // Assertions hold while the enable is high.
    a_resv_zero: assert property (
        @(posedge clock_i) disable iff (srst_i || !ce_i)
        acc_ack_o |-> (acc_rdata_o[62:0] & ~VMASK) == 63'h0)
        else $error("bits above the count width are not zero");

    a_ack_delay: assert property (
        @(posedge clock_i) disable iff (srst_i || !ce_i)
        acc_req_i |-> ##2 acc_ack_o)
        else $error("acknowledge not two cycles after request");

    a_count_inc: assert property (
        @(posedge clock_i) disable iff (srst_i || !ce_i)
        h_hit_q |-> cnt_q[h_idx_q][62:0] == h_exp_q)
        else $error("counter did not add the traffic bytes");

    a_count_write: assert property (
        @(posedge clock_i) disable iff (srst_i || !ce_i)
        wr_cnt ##1 ce_i |-> cnt_q[$past(acc_idx)] == $past(wval))
        else $error("count write did not land in the selected entry");

    a_rme_block: assert property (
        @(posedge clock_i) disable iff (srst_i || !ce_i)
        (!HAS_RME && acc_req_i && acc_space_i[1])
            |-> ##2 acc_rdata_o == 64'h0)
        else $error("root or realm frame answered without the feature");

    a_snap_absent: assert property (
        @(posedge clock_i) disable iff (srst_i || !ce_i)
        (!CAP_OK && acc_req_i && acc_addr_i == OFS_SNAPSHOT)
            |-> ##2 acc_rdata_o == 64'h0)
        else $error("absent snapshot did not read zero");

    a_capture_copy: assert property (
        @(posedge clock_i) disable iff (srst_i || !ce_i)
        cap_fire |-> mem.we && mem.waddr == cap_idx &&
                     mem.wdata == cnt_q[cap_idx])
        else $error("capture did not copy flag and count together");

    a_sel_route: assert property (
        @(posedge clock_i) disable iff (srst_i || !ce_i)
        acc_req_i |-> acc_idx[MW+RW-1:MW] ==
            (INSTANCE_SELECT_SUPPORTED ? sel_q[acc_space_i][SEL_RIS_LSB +: RW] : '0))
        else $error("resource instance routing is wrong");

    c_count_read: cover property (@(posedge clock_i)
        hit_cnt && !acc_wr_i ##2 acc_ack_o);
    c_snap_read: cover property (@(posedge clock_i)
        hit_snap && !acc_wr_i ##2 acc_ack_o);
    c_capture: cover property (@(posedge clock_i) cap_fire);
    c_traffic: cover property (@(posedge clock_i) h_hit_q);
endmodule // lbc_long_counter

// ### tb/lbc_long_counter_tb.sv
// Purpose: Self-checking bench of the long bandwidth counter bank.
// Assumes: Narrow width select; a second copy lacks realm and capture;
//          a third copy runs the wide count.
// Notes:   A bench model predicts every answer; a monitor compares them.
`timescale 1ns/100ps
module lbc_long_counter_tb
    import lbc_pkg::*;
;
    localparam logic [63:0] CNT_MASK =
        (64'h1 << FLAG_BIT) | ((64'h1 << NARROW_W) - 64'h1);
    localparam logic [31:0] SEL_MASK = 32'h0100_0003;

    logic        clock_i, srst_i, ce_i;
    logic        acc_req_i, acc_wr_i;
    logic [1:0]  acc_space_i, trf_space_i, cap_space_i;
    logic [11:0] acc_addr_i;
    logic [63:0] acc_wdata_i, acc_rdata_o, rdata_lim, rdata_wide;
    logic        acc_ack_o, ack_lim, ack_wide, trf_valid_i, cap_i;
    logic [7:0]  trf_ris_i;
    logic [15:0] trf_mon_i, trf_bytes_i;
    int          num_errors   = 0;
    int          total_checks = 0;
    logic [63:0] exp_q[$];
    logic [63:0] lim_q[$];
    logic [63:0] wide_q[$];
    logic [63:0] cnt_m [0:31] = '{default: '0};
    logic [63:0] snap_m[0:31] = '{default: '0};
    logic [31:0] sel_m [0:3]  = '{default: '0};
    logic [63:0] cntw_m [0:31] = '{default: '0};
    logic [63:0] snapw_m[0:31] = '{default: '0};

    lbc_long_counter DUT (
        .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i),
        .acc_req_i(acc_req_i), .acc_wr_i(acc_wr_i),
        .acc_space_i(acc_space_i), .acc_addr_i(acc_addr_i),
        .acc_wdata_i(acc_wdata_i), .acc_ack_o(acc_ack_o),
        .acc_rdata_o(acc_rdata_o), .trf_valid_i(trf_valid_i),
        .trf_space_i(trf_space_i), .trf_ris_i(trf_ris_i),
        .trf_mon_i(trf_mon_i), .trf_bytes_i(trf_bytes_i),
        .cap_i(cap_i), .cap_space_i(cap_space_i));

    // Same stimulus; root, realm and snapshot must all read as zero here.
    lbc_long_counter #(.HAS_RME(1'b0), .HAS_CAPTURE(1'b0)) DUT_LIM (
        .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i),
        .acc_req_i(acc_req_i), .acc_wr_i(acc_wr_i),
        .acc_space_i(acc_space_i), .acc_addr_i(acc_addr_i),
        .acc_wdata_i(acc_wdata_i), .acc_ack_o(ack_lim),
        .acc_rdata_o(rdata_lim), .trf_valid_i(trf_valid_i),
        .trf_space_i(trf_space_i), .trf_ris_i(trf_ris_i),
        .trf_mon_i(trf_mon_i), .trf_bytes_i(trf_bytes_i),
        .cap_i(cap_i), .cap_space_i(cap_space_i));

    // Same stimulus; counts keep all 63 bits and wrap only there.
    lbc_long_counter #(.LONG_WIDTH_SEL(1'b1)) DUT_WIDE (
        .clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i),
        .acc_req_i(acc_req_i), .acc_wr_i(acc_wr_i),
        .acc_space_i(acc_space_i), .acc_addr_i(acc_addr_i),
        .acc_wdata_i(acc_wdata_i), .acc_ack_o(ack_wide),
        .acc_rdata_o(rdata_wide), .trf_valid_i(trf_valid_i),
        .trf_space_i(trf_space_i), .trf_ris_i(trf_ris_i),
        .trf_mon_i(trf_mon_i), .trf_bytes_i(trf_bytes_i),
        .cap_i(cap_i), .cap_space_i(cap_space_i));

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    function automatic int sidx(input int s);
        return s * 8 + sel_m[s][SEL_RIS_LSB] * 4 + sel_m[s][1:0];
    endfunction

    // The wide flag picks the model of the copy with the 63-bit count.
    function automatic logic [63:0] model_rd(input int s,
                                             input logic [11:0] a,
                                             input bit wide);
        case (a)
            OFS_SELECTOR: return {32'h0, sel_m[s]};
            OFS_COUNT:    return wide ? cntw_m[sidx(s)] : cnt_m[sidx(s)];
            OFS_SNAPSHOT: return wide ? snapw_m[sidx(s)] : snap_m[sidx(s)];
            default:      return 64'h0;
        endcase
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // An answer with no note behind it is a mismatch of its own.
    function automatic logic [63:0] take(ref logic [63:0] q[$]);
        if (q.size() == 0) begin
            num_errors++;
            return 64'h0;
        end
        return q.pop_front();
    endfunction

    // The request stays up when accesses follow back to back.
    task automatic acc(input logic w, input int s, input logic [11:0] a,
                       input logic [63:0] d);
        @(posedge clock_i);
        acc_req_i   <= 1'b1;
        acc_wr_i    <= w;
        acc_space_i <= s[1:0];
        acc_addr_i  <= a;
        acc_wdata_i <= d;
        if (w) begin
            exp_q.push_back(64'h0);
            lim_q.push_back(64'h0);
            wide_q.push_back(64'h0);
            if (a == OFS_SELECTOR) sel_m[s] = d[31:0] & SEL_MASK;
            if (a == OFS_COUNT) begin
                cnt_m[sidx(s)]  = d & CNT_MASK;
                cntw_m[sidx(s)] = d;
            end
            if (a == OFS_SNAPSHOT) begin
                snap_m[sidx(s)]  = d & CNT_MASK;
                snapw_m[sidx(s)] = d;
            end
        end else begin
            exp_q.push_back(model_rd(s, a, 1'b0));
            wide_q.push_back(model_rd(s, a, 1'b1));
            lim_q.push_back((s >= 2 || a == OFS_SNAPSHOT) ?
                            64'h0 : model_rd(s, a, 1'b0));
        end
    endtask

    task automatic trf(input int s, input int r, input int m,
                       input logic [15:0] b);
        int          k;
        logic [43:0] v;
        k = s * 8 + r * 4 + m;
        v = cnt_m[k][43:0] + {28'h0, b};
        cnt_m[k] = {cnt_m[k][63], 19'h0, v};
        cntw_m[k] = {cntw_m[k][63], cntw_m[k][62:0] + 63'(b)};
        @(posedge clock_i);
        acc_req_i   <= 1'b0;
        trf_valid_i <= 1'b1;
        trf_space_i <= s[1:0];
        trf_ris_i   <= r[7:0];
        trf_mon_i   <= m[15:0];
        trf_bytes_i <= b;
        @(posedge clock_i);
        trf_valid_i <= 1'b0;
    endtask

    task automatic cap(input int s);
        snap_m[sidx(s)] = cnt_m[sidx(s)];
        snapw_m[sidx(s)] = cntw_m[sidx(s)];
        @(posedge clock_i);
        acc_req_i   <= 1'b0;
        cap_i       <= 1'b1;
        cap_space_i <= s[1:0];
        @(posedge clock_i);
        cap_i <= 1'b0;
    endtask

    task automatic final_report();
        if (num_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Outputs are looked at mid-cycle, after the edge has settled them.
    always @(negedge clock_i) begin
        if (acc_ack_o === 1'b1)
            check(acc_rdata_o, take(exp_q));
        if (ack_lim === 1'b1)
            check(rdata_lim, take(lim_q));
        if (ack_wide === 1'b1)
            check(rdata_wide, take(wide_q));
    end

    initial begin
        repeat (5000) @(posedge clock_i);
        num_errors++;
        final_report();
    end

    initial begin
        int op, s;
        {srst_i, ce_i} = 2'b11;
        {acc_req_i, acc_wr_i, trf_valid_i, cap_i} = 4'h0;
        {acc_space_i, trf_space_i, cap_space_i} = 6'h0;
        acc_addr_i  = 12'h0;
        acc_wdata_i = 64'h0;
        trf_ris_i   = 8'h0;
        trf_mon_i   = 16'h0;
        trf_bytes_i = 16'h0;
        void'($urandom(52));
        repeat (10) @(posedge clock_i);
        srst_i <= 1'b0;
        for (s = 0; s < 4; s++) begin
            acc(0, s, OFS_COUNT, 64'h0);
            acc(0, s, OFS_SNAPSHOT, 64'h0);
            acc(0, s, OFS_SELECTOR, 64'h0);
        end
        for (s = 0; s < 4; s++) begin
            acc(1, s, OFS_SELECTOR, {$urandom, $urandom});
            acc(1, s, OFS_COUNT, {$urandom, $urandom});
        end
        for (s = 0; s < 4; s++) begin
            acc(0, s, OFS_SELECTOR, 64'h0);
            acc(0, s, OFS_COUNT, 64'h0);
        end
        // Wrap at the narrow width must leave the flag alone.
        acc(1, 0, OFS_SELECTOR, 64'h0);
        acc(1, 0, OFS_COUNT, 64'h8000_0fff_ffff_fffe);
        trf(0, 0, 0, 16'h0005);
        acc(0, 0, OFS_COUNT, 64'h0);
        // A frozen enable must hold the pending answer back, not lose it.
        @(posedge clock_i);
        acc_req_i <= 1'b0;
        ce_i      <= 1'b0;
        repeat (3) @(posedge clock_i);
        ce_i <= 1'b1;
        for (s = 0; s < 4; s++)
            cap(s);
        for (s = 0; s < 4; s++) begin
            trf(s, sel_m[s][SEL_RIS_LSB], sel_m[s][1:0],
                16'($urandom));
            acc(0, s, OFS_SNAPSHOT, 64'h0);
            acc(0, s, OFS_COUNT, 64'h0);
        end
        acc(1, 1, OFS_SNAPSHOT, {$urandom, $urandom});
        acc(0, 1, OFS_SNAPSHOT, 64'h0);
        acc(1, 0, 12'h888, {$urandom, $urandom});
        acc(0, 0, 12'h888, 64'h0);
        for (int i = 0; i < 300; i++) begin
            op = $urandom_range(0, 4);
            s  = $urandom_range(0, 3);
            case (op)
                0: trf(s, $urandom_range(0, 1), $urandom_range(0, 3),
                       16'($urandom));
                1: acc(1, s, OFS_SELECTOR, {$urandom, $urandom});
                2: acc(1, s, OFS_COUNT, {$urandom, $urandom});
                3: acc(0, s, OFS_COUNT, 64'h0);
                default: begin
                    cap(s);
                    acc(0, s, OFS_SNAPSHOT, 64'h0);
                end
            endcase
        end
        @(posedge clock_i);
        acc_req_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        if (exp_q.size() != 0 || lim_q.size() != 0 || wide_q.size() != 0)
            num_errors++;
        final_report();
    end
endmodule // lbc_long_counter_tb
